// *** rtl/htcos_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "htcos_params.svh"

module htcos_top #(
	parameter int COEF_W = `HTCOS_COEF_W
) (
	// Clock and reset
	input  wire logic                        CLK,
	input  wire logic                        RST,
	// APB slave (configuration link side)
	input  wire logic                        PSEL,
	input  wire logic                        PENABLE,
	input  wire logic                        PWRITE,
	input  wire logic [`HTCOS_ADDR_W-1:0]    PADDR,
	input  wire logic [31:0]                 PWDATA,
	input  wire logic [3:0]                  PSTRB,
	output logic                             PREADY,
	output logic [31:0]                      PRDATA,
	output logic                             PSLVERR,
	// Sensor front end
	input  wire htcos_pkg::htcos_temp_t      JUNCTION_TEMP,
	input  wire htcos_pkg::htcos_field_t     RAW_FIELD_MAIN,
	input  wire htcos_pkg::htcos_field_t     RAW_FIELD_SUB,
	// Output words
	output var htcos_pkg::htcos_out_t        OUT_MAIN,
	output var htcos_pkg::htcos_out_t        OUT_SUB
);
	import htcos_pkg::*;

	localparam int NCH = `HTCOS_NCH;
	localparam int DW  = `HTCOS_D_W;
	localparam int SW  = `HTCOS_S_W;
	localparam int PW  = `HTCOS_P_W;
	localparam int GW  = `HTCOS_G_W;
	localparam int CW  = COEF_W + 1;

	logic [2:0]      blk;
	logic [4:0]      off;
	logic            setup;
	logic            wr_acc;
	logic            run;
	htcos_temp_t     tj;
	htcos_internal_temperature_t     internal_temperature;
	logic [31:0]     rd_word;
	logic            addr_ok;
	logic            read_only;
	logic            next_err;
	logic [2:0]      ch_rel;

	wire  [31:0]     ch_rdata [NCH];
	wire             ch_ok    [NCH];
	wire             ch_ro    [NCH];
	wire             ch_hclip [NCH];
	wire             ch_oclip [NCH];
	htcos_field_t    raw_in   [NCH];

	assign blk    = PADDR[`HTCOS_BLK_HI:`HTCOS_BLK_LO];
	assign off    = PADDR[`HTCOS_OFF_HI:0];
	assign setup  = PSEL && !PENABLE;
	assign ch_rel = blk - `HTCOS_CH_BLK0;

	assign raw_in[0] = RAW_FIELD_MAIN;
	assign raw_in[1] = RAW_FIELD_SUB;

	// Byte-lane merge for APB write strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (wd & m);
	endfunction

	// Zero-wait slave: decode in setup, answer in the first access cycle
	assign PREADY = 1'b1;

	// Writes land only on mapped, writable words
	assign wr_acc = PSEL && PENABLE && PWRITE && !PSLVERR;

	// Temperature sample; internal scale is 32 per degree
	always_ff @(posedge CLK) begin
		if (RST) begin
			tj <= '0;
		end else if (run) begin
			tj <= JUNCTION_TEMP;
		end
	end

	assign internal_temperature = $signed(13'(tj)) <<< `HTCOS_INTERNAL_TEMPERATURE_SHIFT;

	// Global control
	always_ff @(posedge CLK) begin
		if (RST) begin
			run <= `HTCOS_RUN_RST;
		end else if (wr_acc && blk == `HTCOS_GLOBAL_BLK && off == `HTCOS_OFF_CTRL && PSTRB[0]) begin
			run <= PWDATA[`HTCOS_CTRL_RUN];
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_ch
			logic [COEF_W-1:0]       tc1;
			logic [COEF_W-1:0]       tc2;
			htcos_temp_t             t0;
			htcos_gain_t             gain;
			htcos_out_t              zero;
			logic                    ch_wr;
			logic [31:0]             rd;
			logic                    ok;
			logic                    ro;
			logic signed [DW-1:0]    d1;
			htcos_field_t            raw1;
			htcos_field_t            raw2;
			logic signed [CW-1:0]    tc1_dev;
			logic signed [CW-1:0]    tc2_dev;
			logic signed [SW-1:0]    poly;
			logic signed [SW-1:0]    next_s;
			logic signed [SW-1:0]    s2;
			logic signed [PW-1:0]    scaled;
			logic [15:0]             next_calibrated_field_value;
			logic                    next_hclip;
			htcos_field_t            calibrated_field_value;
			logic                    hclip;
			logic signed [GW-1:0]    out_sum;
			logic [12:0]             next_out;
			logic                    next_oclip;
			htcos_out_t              out_q;
			logic                    oclip;

			assign ch_wr = wr_acc && blk == `HTCOS_CH_BLK0 + 3'(ch);

			// Coefficients reset to the flat-sensitivity preset
			always_ff @(posedge CLK) begin
				if (RST) begin
					tc1 <= `HTCOS_TC1_RST;
					tc2 <= `HTCOS_TC2_RST;
				end else if (ch_wr && off == `HTCOS_OFF_TC1) begin
					tc1 <= COEF_W'(merge(32'(tc1), PWDATA, PSTRB));
				end else if (ch_wr && off == `HTCOS_OFF_TC2) begin
					tc2 <= COEF_W'(merge(32'(tc2), PWDATA, PSTRB));
				end
			end

			always_ff @(posedge CLK) begin
				if (RST) begin
					t0 <= `HTCOS_T0_RST;
				end else if (ch_wr && off == `HTCOS_OFF_T0) begin
					t0 <= 8'(merge(32'($unsigned(t0)), PWDATA, PSTRB));
				end
			end

			always_ff @(posedge CLK) begin
				if (RST) begin
					gain <= `HTCOS_GAIN_RST;
					zero <= `HTCOS_ZERO_RST;
				end else if (ch_wr && off == `HTCOS_OFF_GAIN) begin
					gain <= 14'(merge(32'($unsigned(gain)), PWDATA, PSTRB));
				end else if (ch_wr && off == `HTCOS_OFF_ZERO) begin
					zero <= 13'(merge(32'(zero), PWDATA, PSTRB));
				end
			end

			// Stage 1: distance from reference temperature
			always_ff @(posedge CLK) begin
				if (RST) begin
					d1   <= '0;
					raw1 <= '0;
				end else if (run) begin
					d1   <= DW'(internal_temperature) - (DW'(t0) <<< `HTCOS_INTERNAL_TEMPERATURE_SHIFT);
					raw1 <= raw_in[ch];
				end
			end

			// Stage 2: factor scaled by 2^35, exact for every coefficient
			assign tc1_dev = $signed({1'b0, tc1}) - $signed(CW'(`HTCOS_TC1_NEUTRAL));
			assign tc2_dev = $signed({1'b0, tc2}) - $signed(CW'(`HTCOS_TC2_NEUTRAL));
			assign poly    = (SW'(tc1_dev) <<< `HTCOS_TC1_SHIFT)
				+ SW'(tc2_dev) * SW'(d1) * $signed(SW'(`HTCOS_TC2_MUL));
			assign next_s  = ($signed(SW'(1)) <<< `HTCOS_S_FRAC) + SW'(d1) * poly;

			always_ff @(posedge CLK) begin
				if (RST) begin
					s2   <= '0;
					raw2 <= '0;
				end else if (run) begin
					s2   <= next_s;
					raw2 <= raw1;
				end
			end

			// Stage 3: compensated field, floored, clamped to 16 bits
			assign scaled = (PW'(raw2) * PW'(s2)) >>> `HTCOS_S_FRAC;

			htcos_sat #(
				.IN_W       (PW),
				.OUT_W      (16),
				.SIGNED_OUT (1'b1)
			) u_calibrated_field_value_sat (
				.din     (scaled),
				.dout    (next_calibrated_field_value),
				.clipped (next_hclip)
			);

			always_ff @(posedge CLK) begin
				if (RST) begin
					calibrated_field_value  <= '0;
					hclip <= 1'b0;
				end else if (run) begin
					calibrated_field_value  <= $signed(next_calibrated_field_value);
					hclip <= next_hclip;
				end
			end

			// Stage 4: gain over 4096 plus zero point
			assign out_sum = ((GW'(gain) * GW'(calibrated_field_value)) >>> `HTCOS_GAIN_FRAC) + $signed(GW'(zero));

			htcos_sat #(
				.IN_W       (GW),
				.OUT_W      (13),
				.SIGNED_OUT (1'b0)
			) u_out_sat (
				.din     (out_sum),
				.dout    (next_out),
				.clipped (next_oclip)
			);

			always_ff @(posedge CLK) begin
				if (RST) begin
					out_q <= `HTCOS_ZERO_RST;
					oclip <= 1'b0;
				end else if (run) begin
					out_q <= next_out;
					oclip <= next_oclip;
				end
			end

			// Channel register readback
			always_comb begin
				rd = '0;
				ok = 1'b1;
				ro = 1'b0;
				unique case (off)
					`HTCOS_OFF_TC1:  rd = 32'(tc1);
					`HTCOS_OFF_TC2:  rd = 32'(tc2);
					`HTCOS_OFF_T0:   rd = 32'($unsigned(t0));
					`HTCOS_OFF_GAIN: rd = 32'($unsigned(gain));
					`HTCOS_OFF_ZERO: rd = 32'(zero);
					`HTCOS_OFF_CALIBRATED_FIELD_VALUE: begin
						rd = 32'($unsigned(calibrated_field_value));
						ro = 1'b1;
					end
					`HTCOS_OFF_OUT: begin
						rd = 32'(out_q);
						ro = 1'b1;
					end
					default: ok = 1'b0;
				endcase
			end

			assign ch_rdata[ch] = rd;
			assign ch_ok[ch]    = ok;
			assign ch_ro[ch]    = ro;
			assign ch_hclip[ch] = hclip;
			assign ch_oclip[ch] = oclip;
		end
	endgenerate

	assign OUT_MAIN = g_ch[0].out_q;
	assign OUT_SUB  = g_ch[1].out_q;

	// Address decode and read word
	always_comb begin
		rd_word   = '0;
		addr_ok   = 1'b0;
		read_only = 1'b0;
		if (PADDR[1:0] == 2'h0) begin
			if (blk == `HTCOS_GLOBAL_BLK) begin
				addr_ok = 1'b1;
				unique case (off)
					`HTCOS_OFF_CTRL: rd_word = 32'(run);
					`HTCOS_OFF_STAT: begin
						rd_word   = {28'h0000000, ch_oclip[1], ch_oclip[0], ch_hclip[1], ch_hclip[0]};
						read_only = 1'b1;
					end
					`HTCOS_OFF_TJ: begin
						rd_word   = 32'($unsigned(tj));
						read_only = 1'b1;
					end
					`HTCOS_OFF_INTERNAL_TEMPERATURE: begin
						rd_word   = 32'($unsigned(internal_temperature));
						read_only = 1'b1;
					end
					default: addr_ok = 1'b0;
				endcase
			end else if (blk >= `HTCOS_CH_BLK0 && int'(ch_rel) < NCH) begin
				rd_word   = ch_rdata[ch_rel[0]];
				addr_ok   = ch_ok[ch_rel[0]];
				read_only = ch_ro[ch_rel[0]];
			end
		end
	end

	// Unmapped, misaligned or read-only writes answer with an error
	assign next_err = !addr_ok || (PWRITE && read_only);

	// Answer is captured in the setup cycle so it leaves a flop
	always_ff @(posedge CLK) begin
		if (RST) begin
			PRDATA  <= '0;
			PSLVERR <= 1'b0;
		end else if (setup) begin
			PRDATA  <= PWRITE ? 32'h00000000 : rd_word;
			PSLVERR <= next_err;
		end else if (!PSEL) begin
			PSLVERR <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// *** rtl/htcos_params.svh ***
`ifndef HTCOS_PARAMS_SVH
`define HTCOS_PARAMS_SVH

// Channels and widths
`define HTCOS_NCH          2
`define HTCOS_COEF_W       12
`define HTCOS_ADDR_W       8
`define HTCOS_D_W          16
`define HTCOS_S_W          48
`define HTCOS_P_W          64
`define HTCOS_G_W          32

// Polynomial constants
`define HTCOS_TC1_NEUTRAL  315
`define HTCOS_TC2_NEUTRAL  256
`define HTCOS_INTERNAL_TEMPERATURE_SHIFT   5
`define HTCOS_S_FRAC       35
`define HTCOS_TC1_SHIFT    13
`define HTCOS_TC2_MUL      4
`define HTCOS_GAIN_FRAC    12

// Reset (delivery) values
`define HTCOS_TC1_RST      12'h13B
`define HTCOS_TC2_RST      12'h100
`define HTCOS_T0_RST       8'h19
`define HTCOS_GAIN_RST     14'h1000
`define HTCOS_ZERO_RST     13'h0000
`define HTCOS_RUN_RST      1'b1

// Register map: block select in address bits 7:5, offset in bits 4:0
`define HTCOS_BLK_HI       7
`define HTCOS_BLK_LO       5
`define HTCOS_OFF_HI       4
`define HTCOS_GLOBAL_BLK   3'h0
`define HTCOS_CH_BLK0      3'h1
`define HTCOS_OFF_CTRL     5'h00
`define HTCOS_OFF_STAT     5'h04
`define HTCOS_OFF_TJ       5'h08
`define HTCOS_OFF_INTERNAL_TEMPERATURE     5'h0C
`define HTCOS_OFF_TC1      5'h00
`define HTCOS_OFF_TC2      5'h04
`define HTCOS_OFF_T0       5'h08
`define HTCOS_OFF_GAIN     5'h0C
`define HTCOS_OFF_ZERO     5'h10
`define HTCOS_OFF_CALIBRATED_FIELD_VALUE     5'h14
`define HTCOS_OFF_OUT      5'h18
`define HTCOS_CTRL_RUN     0

`endif

// *** rtl/htcos_pkg.sv ***
package htcos_pkg;
	typedef logic signed [15:0] htcos_field_t;
	typedef logic        [12:0] htcos_out_t;
	typedef logic signed [13:0] htcos_gain_t;
	typedef logic signed [7:0]  htcos_temp_t;
	typedef logic signed [12:0] htcos_internal_temperature_t;
endpackage

// *** rtl/htcos_sat.sv ***
`timescale 1ns/1ps
`default_nettype none

module htcos_sat #(
	parameter int IN_W       = 64,
	parameter int OUT_W      = 16,
	parameter bit SIGNED_OUT = 1'b1
) (
	// Wide value in
	input  wire logic signed [IN_W-1:0]  din,
	// Clamped value out
	output logic             [OUT_W-1:0] dout,
	output logic                         clipped
);
	localparam longint HI_L = SIGNED_OUT ? ((64'sd1 <<< (OUT_W - 1)) - 64'sd1) : ((64'sd1 <<< OUT_W) - 64'sd1);
	localparam longint LO_L = SIGNED_OUT ? -(64'sd1 <<< (OUT_W - 1)) : 64'sd0;
	localparam logic signed [IN_W-1:0] HI = IN_W'(HI_L);
	localparam logic signed [IN_W-1:0] LO = IN_W'(LO_L);

	// Clamp instead of wrap so a far overrange never folds to the other end
	always_comb begin
		if (din > HI) begin
			dout    = HI[OUT_W-1:0];
			clipped = 1'b1;
		end else if (din < LO) begin
			dout    = LO[OUT_W-1:0];
			clipped = 1'b1;
		end else begin
			dout    = din[OUT_W-1:0];
			clipped = 1'b0;
		end
	end
endmodule

`default_nettype wire

// *** verification/htcos_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "htcos_params.svh"
module htcos_checker (
	// Clock and reset
	input wire logic                     CLK,
	input wire logic                     RST,
	// APB
	input wire logic                     PSEL,
	input wire logic                     PENABLE,
	input wire logic                     PWRITE,
	input wire logic [`HTCOS_ADDR_W-1:0] PADDR,
	input wire logic [31:0]              PWDATA,
	input wire logic [3:0]               PSTRB,
	input wire logic                     PREADY,
	input wire logic [31:0]              PRDATA,
	input wire logic                     PSLVERR,
	// Datapath
	input wire htcos_pkg::htcos_temp_t   JUNCTION_TEMP,
	input wire htcos_pkg::htcos_field_t  RAW_FIELD_MAIN,
	input wire htcos_pkg::htcos_field_t  RAW_FIELD_SUB,
	input wire htcos_pkg::htcos_out_t    OUT_MAIN,
	input wire htcos_pkg::htcos_out_t    OUT_SUB
);
	import htcos_pkg::*;
	logic setup;
	assign setup = PSEL && !PENABLE;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_ready_high: assert property (PREADY) else $error("ready low");
	// Error flag lags the select by one edge
	a_err_idle: assert property (!PSEL && !$past(PSEL) |-> !PSLVERR) else $error("error while idle");
	a_bad_addr: assert property (setup && (PADDR[1:0] != 2'h0 || PADDR[7:6] == 2'h3) |=> PSLVERR)
		else $error("bad address accepted");
	a_ro_write: assert property (setup && PWRITE && PADDR == 8'h34 |=> PSLVERR)
		else $error("field value written");
	a_ctrl_read: assert property (setup && !PWRITE && PADDR == 8'h00 |=> !PSLVERR)
		else $error("control read refused");
	a_write_rdata: assert property (setup && PWRITE |=> PRDATA == 32'h0) else $error("read data on write");
	// Eight quiet cycles cover the deepest pipeline path
	a_main_steady: assert property (($stable(RAW_FIELD_MAIN) && $stable(JUNCTION_TEMP) && !PSEL) [*8]
		|=> $stable(OUT_MAIN)) else $error("main output moved");
	a_sub_steady: assert property (($stable(RAW_FIELD_SUB) && $stable(JUNCTION_TEMP) && !PSEL) [*8]
		|=> $stable(OUT_SUB)) else $error("sub output moved");
endmodule
bind htcos_top htcos_checker u_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
	.JUNCTION_TEMP(JUNCTION_TEMP), .RAW_FIELD_MAIN(RAW_FIELD_MAIN), .RAW_FIELD_SUB(RAW_FIELD_SUB),
	.OUT_MAIN(OUT_MAIN), .OUT_SUB(OUT_SUB));
`default_nettype wire

// *** verification/htcos_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module htcos_host (
	// Clock
	input  wire logic        clk,
	// APB master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	// Wait overrun
	output logic             timed_out
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		timed_out = 1'b0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) timed_out = 1'b1;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines must not keep the old value
		pwrite <= ~w;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import htcos_pkg::*;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         psel, penable, pwrite, pready, pslverr, tmo;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata;
	logic [3:0]   pstrb;
	htcos_temp_t  tj = '0;
	htcos_field_t raw_m = '0;
	htcos_field_t raw_s = '0;
	htcos_out_t   out_m, out_s;
	int           n_errors = 0;
	int           compares = 0;
	logic [15:0]  rnd = 16'h9949;
	always #25 clk = ~clk;
	htcos_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .timed_out(tmo));
	htcos_top u_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
		.JUNCTION_TEMP(tj), .RAW_FIELD_MAIN(raw_m), .RAW_FIELD_SUB(raw_s), .OUT_MAIN(out_m), .OUT_SUB(out_s));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic int model(input int tv, t0, tc1, tc2, raw, g, z, output int calibrated_field_value);
		longint d, s, o;
		d = 32 * tv - 32 * t0;
		s = (longint'(1) <<< 35) + d * ((tc1 - 315) * 8192 + (tc2 - 256) * d * 4);
		o = (raw * s) >>> 35;
		calibrated_field_value = o > 32767 ? 32767 : o < -32768 ? -32768 : int'(o);
		o = ((g * calibrated_field_value) >>> 12) + z;
		return o > 8191 ? 8191 : o < 0 ? 0 : int'(o);
	endfunction
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] q;
		logic        e;
		u_host.xfer(1'b0, a, 32'h0, q, e);
		check(nm, q, exp);
		check("rd_err", e, 1'b0);
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input int d, input logic e_exp);
		logic [31:0] q;
		logic        e;
		u_host.xfer(w, a, 32'(d), q, e);
		check("acc_err", e, e_exp);
	endtask
	task automatic load(input int c, t0, tc1, tc2, g, z);
		logic [7:0] b;
		b = 8'h20 << c;
		acc(1'b1, b, tc1, 1'b0);
		acc(1'b1, b + 8'h04, tc2, 1'b0);
		acc(1'b1, b + 8'h08, t0 & 255, 1'b0);
		acc(1'b1, b + 8'h0C, g & 32'h3FFF, 1'b0);
		acc(1'b1, b + 8'h10, z, 1'b0);
	endtask
	task automatic stop_test;
		check("wait_limit", tmo, 1'b0);
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		int          t0, tc1, tc2, g, z, tv, rm, rs, em, es, hm, hs, h1, h2;
		logic [7:0]  b;
		logic [31:0] q;
		logic        e;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int c = 0; c < 2; c++) begin
			b = 8'h20 << c;
			rd(b, 32'h13B, "tc1");
			rd(b + 8'h04, 32'h100, "tc2");
			rd(b + 8'h0C, 32'h1000, "gain");
			rd(b + 8'h10, 32'h0, "zero");
		end
		rd(8'h00, 32'h1, "ctrl");
		acc(1'b0, 8'h02, 0, 1'b1);
		acc(1'b0, 8'hE0, 0, 1'b1);
		acc(1'b1, 8'h34, 0, 1'b1);
		acc(1'b1, 8'h58, 0, 1'b1);
		// Two points at the reference temperature, targets span most of the range
		tj <= 8'sd25;
		raw_m <= -16'sd8000;
		repeat (8) @(posedge clk);
		u_host.xfer(1'b0, 8'h34, 32'h0, q, e);
		h1 = $signed(q[15:0]);
		raw_m <= 16'sd8000;
		repeat (8) @(posedge clk);
		u_host.xfer(1'b0, 8'h34, 32'h0, q, e);
		h2 = $signed(q[15:0]);
		g = 4096 * (7000 - 1000) / (h2 - h1);
		z = 1000 - (g * h1) / 4096;
		acc(1'b1, 8'h2C, g & 32'h3FFF, 1'b0);
		acc(1'b1, 8'h30, z, 1'b0);
		repeat (8) @(posedge clk);
		check("two_point", out_m, 13'd7000);
		for (int i = 0; i < 24; i++) begin
			rnd = lfsr(rnd);
			t0 = rnd[4:0];
			tv = (i % 4 == 0) ? t0 : 32'($signed(rnd[15:8]));
			rnd = lfsr(rnd);
			tc1 = 251 + rnd[6:0];
			tc2 = 192 + rnd[14:8];
			rnd = lfsr(rnd);
			g = $signed(rnd[13:0]);
			z = rnd[15:3];
			rnd = lfsr(rnd);
			rm = $signed(rnd);
			rnd = lfsr(rnd);
			rs = $signed(rnd);
			// Gain extremes drive the output into both limits
			if (i < 2) begin
				g = i ? -8192 : 8191;
				rm = 32767;
				tv = t0;
				z = 100;
			end
			if (i == 2) begin
				tc1 = 4095;
				tv = 127;
				rm = 30000;
			end
			for (int c = 0; c < 2; c++) load(c, t0, tc1, tc2, g, z);
			tj <= 8'(tv);
			raw_m <= 16'(rm);
			raw_s <= 16'(rs);
			repeat (8) @(posedge clk);
			em = model(tv, t0, tc1, tc2, rm, g, z, hm);
			es = model(tv, t0, tc1, tc2, rs, g, z, hs);
			check("out_main", out_m, em);
			check("out_sub", out_s, es);
			rd(8'h34, 32'(hm) & 32'hFFFF, "calibrated_field_value_main");
			rd(8'h54, 32'(hs) & 32'hFFFF, "calibrated_field_value_sub");
			rd(8'h38, em, "out_reg");
			rd(8'h08, tv & 255, "tj");
			rd(8'h0C, (32 * tv) & 32'h1FFF, "internal_temperature");
		end
		// Flat preset, fixed field, three temperatures: output must not move
		for (int c = 0; c < 2; c++) load(c, 25, 315, 256, 4096, 0);
		raw_m <= 16'sd4000;
		raw_s <= -16'sd4000;
		for (int k = 0; k < 3; k++) begin
			tv = (k == 0) ? -40 : (k == 1) ? 25 : 120;
			tj <= 8'(tv);
			repeat (8) @(posedge clk);
			rd(8'h08, tv & 255, "sweep_tj");
			rd(8'h38, model(tv, 25, 315, 256, 4000, 4096, 0, hm), "sweep_out");
			check("sweep_sub", out_s, 13'd0);
		end
		// Only the sub output is pinned at its lower limit
		rd(8'h04, 32'h8, "stat");
		// Cleared run bit freezes the pipeline
		acc(1'b1, 8'h00, 0, 1'b0);
		raw_m <= 16'sd100;
		repeat (8) @(posedge clk);
		check("frozen", out_m, 13'd4000);
		acc(1'b1, 8'h00, 1, 1'b0);
		repeat (8) @(posedge clk);
		check("resumed", out_m, 13'd100);
		stop_test();
	end
endmodule
`default_nettype wire
